// file: src/msc_pkg.sv
// Functional notes
// - out-of-range flag when enabled; off by default
// - minimum input limit, default zero, 1e-5 steps
// - maximum input limit, default zero, 1e-5 steps
// - optional first-order low-pass with set time constant
// - out-of-range flag offered as internal signal
// - signal loss freezes last valid measured value
// - update cycle in 5 ms steps, 150 ms default
// - output float or floor, ceiling, nearest integer
// - default two-point line, inputs zero and one
// - up to twenty user points replace the line
// - curve input and output readable as indications
// - curve enable, disabled by default
`default_nettype none
package msc_pkg;
  ////////////////////////////////////////////////////////////////////////
  // bus geometry and register offsets (byte addresses)
  localparam int ADDR_W = 9;
  localparam logic [8:0] OFF_CTRL = 9'h000;
  localparam logic [8:0] OFF_UPD = 9'h004;
  localparam logic [8:0] OFF_TAU = 9'h008;
  localparam logic [8:0] OFF_MIN = 9'h00C;
  localparam logic [8:0] OFF_MAX = 9'h010;
  localparam logic [8:0] OFF_X1 = 9'h014;
  localparam logic [8:0] OFF_Y1 = 9'h018;
  localparam logic [8:0] OFF_X2 = 9'h01C;
  localparam logic [8:0] OFF_Y2 = 9'h020;
  localparam logic [8:0] OFF_NPTS = 9'h024;
  localparam logic [8:0] OFF_STAT = 9'h028;
  localparam logic [8:0] OFF_IRQ = 9'h02C;
  localparam logic [8:0] OFF_MASK = 9'h030;
  localparam logic [8:0] OFF_CIN = 9'h034;
  localparam logic [8:0] OFF_COUT = 9'h038;
  localparam logic [5:0] TBL_BASE_DW = 6'h10; // table starts at 0x080
  ////////////////////////////////////////////////////////////////////////
  // control field positions
  localparam int CTRL_EN = 0;
  localparam int CTRL_FILT = 1;
  localparam int CTRL_OOR = 2;
  localparam int CTRL_PTS = 3;
  localparam int CTRL_RND = 4;
  localparam int IRQ_OOR = 0;
  localparam int IRQ_UPD = 1;
  localparam int IRQ_LOST = 2;
  localparam int IRQ_W = 3;
  ////////////////////////////////////////////////////////////////////////
  // values in units of 1e-5; curve table size
  localparam logic [31:0] SCALE = 32'h000186A0;
  localparam logic [31:0] HALF_SCALE = SCALE >> 1;
  localparam logic [4:0] MAX_PTS = 5'h14;
  localparam logic [4:0] RST_NPTS = 5'h02;
  localparam logic [31:0] RST_LIMIT = 32'h00000000;
  localparam logic [31:0] RST_X1 = 32'h00000000;
  localparam logic [31:0] RST_X2 = SCALE;
  localparam logic [31:0] RST_Y = 32'h00000000;
  localparam logic [31:0] RST_TAU_MS = 32'h000003E8;
  ////////////////////////////////////////////////////////////////////////
  // timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int STEP_TIME_NS = 5000000;
  localparam int STEP_CYCLES = STEP_TIME_NS / CLK_PERIOD_NS;
  localparam logic [31:0] STEP_MS = 32'h00000005;
  localparam logic [31:0] UPD_DEFAULT_MS = 32'h00000096;
  localparam logic [15:0] RST_UPD = 16'(UPD_DEFAULT_MS / STEP_MS);
  ////////////////////////////////////////////////////////////////////////
  // enumerations
  typedef enum logic [1:0] {
    RND_FLOAT = 2'h0,
    RND_FLOOR = 2'h1,
    RND_CEIL = 2'h2,
    RND_NEAR = 2'h3
  } msc_round_t;
  typedef enum logic [3:0] {
    ST_IDLE = 4'h0,
    ST_FILT = 4'h1,
    ST_CHK = 4'h3,
    ST_RD = 4'h2,
    ST_CMP = 4'h6,
    ST_DIV = 4'h7,
    ST_RES = 4'h5,
    ST_RND = 4'h4,
    ST_DONE = 4'hC
  } msc_state_t;
  ////////////////////////////////////////////////////////////////////////
  // byte-lane merge of a bus write into an old value
  function automatic logic [31:0] wr_merge(input logic [31:0] old,
                                           input logic [31:0] dat,
                                           input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (sel[b]) begin
        r[b*8 +: 8] = dat[b*8 +: 8];
      end
    end
    return r;
  endfunction : wr_merge
  // magnitude of a signed 64-bit value
  function automatic logic [63:0] mag64(input logic signed [63:0] v);
    return v[63] ? 64'(-v) : 64'(v);
  endfunction : mag64
endpackage : msc_pkg
`default_nettype wire

// file: src/msc_div.sv
`timescale 1ns/100ps
`default_nettype none
module msc_div (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic start_i,
  input wire logic [63:0] num_i,
  input wire logic [31:0] den_i,
  output logic done_o,
  output logic [63:0] quot_o,
  output logic [31:0] rem_o
);
  logic [6:0] cnt_ff;
  logic [31:0] den_ff;
  logic [32:0] sh;
  ////////////////////////////////////////////////////////////////////////
  // restoring divider, one quotient bit a cycle; slow but tiny, and the
  // update cycle leaves thousands of clocks to spare
  assign sh = {rem_o, quot_o[63]};
  always_ff @(posedge clk_i) begin
    done_o <= 1'b0;
    if (rst_i) begin
      cnt_ff <= 7'h00;
      den_ff <= 32'h00000000;
      quot_o <= 64'h0000000000000000;
      rem_o <= 32'h00000000;
    end else if (start_i) begin
      cnt_ff <= 7'h40;
      den_ff <= den_i;
      quot_o <= num_i;
      rem_o <= 32'h00000000;
    end else if (cnt_ff != 7'h00) begin
      if (sh >= {1'b0, den_ff}) begin
        rem_o <= 32'(sh - {1'b0, den_ff});
        quot_o <= {quot_o[62:0], 1'b1};
      end else begin
        rem_o <= sh[31:0];
        quot_o <= {quot_o[62:0], 1'b0};
      end
      cnt_ff <= cnt_ff - 7'h01;
      done_o <= (cnt_ff == 7'h01);
    end
  end
endmodule : msc_div
`default_nettype wire

// file: src/msc_point_mem.sv
`timescale 1ns/100ps
`default_nettype none
module msc_point_mem (
  input wire logic clk_i,
  input wire logic wr_en_i,
  input wire logic wr_hi_i,
  input wire logic [3:0] wr_sel_i,
  input wire logic [4:0] wr_idx_i,
  input wire logic [31:0] wr_data_i,
  input wire logic [4:0] rd_idx_i,
  output logic [63:0] rd_data_o
);
  import msc_pkg::*;
  // each word holds one point: input in low half, output in high half
  logic [63:0] mem [MAX_PTS];
  ////////////////////////////////////////////////////////////////////////
  // byte-lane write, registered read every cycle
  always_ff @(posedge clk_i) begin
    if (wr_en_i && wr_idx_i < MAX_PTS) begin
      for (int b = 0; b < 4; b++) begin
        if (wr_sel_i[b]) begin
          mem[wr_idx_i][{wr_hi_i, 5'h00} + 6'(b*8) +: 8] <=
            wr_data_i[b*8 +: 8];
        end
      end
    end
    rd_data_o <= (rd_idx_i < MAX_PTS) ? mem[rd_idx_i] : 64'h0;
  end
endmodule : msc_point_mem
`default_nettype wire

// file: src/msc_top.sv
`timescale 1ns/100ps
`default_nettype none
module msc_top #(
  parameter int STEP_CYCLES_P = msc_pkg::STEP_CYCLES
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [msc_pkg::ADDR_W-1:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic [31:0] meas_i,
  input wire logic meas_stb_i,
  input wire logic sig_ok_i,
  output logic oor_o,
  output logic [31:0] curve_in_o,
  output logic [31:0] curve_out_o,
  output logic upd_o,
  output logic irq_o
);
  import msc_pkg::*;
  logic en_ff, filt_en_ff, oor_en_ff, pts_en_ff;
  msc_round_t rnd_ff;
  logic [15:0] upd_ff;
  logic [31:0] tau_ff, min_ff, max_ff, x1_ff, y1_ff, x2_ff, y2_ff;
  logic [4:0] npts_ff;
  logic [IRQ_W-1:0] irq_ff, mask_ff, irq_set;
  logic req, is_tbl, tbl_ok, tbl_ph_ff, wr, rd_tbl;
  logic [5:0] tidx;
  logic [31:0] rd_val, ctrl_val, wmask;
  msc_state_t st_ff;
  logic [31:0] meas_ff, curx_ff, filt_ff, base_ff, res_ff, prevx_ff, prevy_ff;
  logic filt_init_ff, neg_ff, oor_new_ff, sig_d_ff, tick;
  logic [4:0] idx_ff;
  logic [31:0] pre_ff;
  logic [15:0] step_ff;
  logic div_start_ff, div_done;
  logic [63:0] div_a_ff, div_q;
  logic [31:0] div_b_ff, div_r;
  logic [63:0] mem_q;
  logic [31:0] px, py, x0, y0, xe, ye, dt_ms, q32, rnd_mag;
  logic signed [63:0] fprod, iprod;
  logic rnd_up;
  ////////////////////////////////////////////////////////////////////////
  // bus decode; the point table sits above the plain registers
  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
  assign wr = req & wb_we_i;
  assign is_tbl = wb_adr_i[8] | wb_adr_i[7];
  assign tidx = 6'(wb_adr_i[8:3] - TBL_BASE_DW);
  assign tbl_ok = is_tbl & (tidx < 6'(MAX_PTS));
  assign rd_tbl = req & ~wb_we_i & tbl_ok;
  assign wmask = wr_merge(32'h0, wb_dat_i, wb_sel_i);
  assign ctrl_val = {26'h0, rnd_ff, pts_en_ff, oor_en_ff, filt_en_ff, en_ff};

  // software register writes, reset values per control
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      {en_ff, filt_en_ff, oor_en_ff, pts_en_ff} <= 4'h0;
      rnd_ff <= RND_FLOAT;
      upd_ff <= RST_UPD;
      tau_ff <= RST_TAU_MS;
      min_ff <= RST_LIMIT;
      max_ff <= RST_LIMIT;
      x1_ff <= RST_X1;
      x2_ff <= RST_X2;
      y1_ff <= RST_Y;
      y2_ff <= RST_Y;
      npts_ff <= RST_NPTS;
      mask_ff <= '0;
    end else if (wr && !is_tbl) begin
      case (wb_adr_i)
        OFF_CTRL: begin
          {rnd_ff, pts_en_ff, oor_en_ff, filt_en_ff, en_ff} <=
            6'(wr_merge(ctrl_val, wb_dat_i, wb_sel_i));
        end
        OFF_UPD: upd_ff <= 16'(wr_merge({16'h0, upd_ff}, wb_dat_i, wb_sel_i));
        OFF_TAU: tau_ff <= wr_merge(tau_ff, wb_dat_i, wb_sel_i);
        OFF_MIN: min_ff <= wr_merge(min_ff, wb_dat_i, wb_sel_i);
        OFF_MAX: max_ff <= wr_merge(max_ff, wb_dat_i, wb_sel_i);
        OFF_X1: x1_ff <= wr_merge(x1_ff, wb_dat_i, wb_sel_i);
        OFF_Y1: y1_ff <= wr_merge(y1_ff, wb_dat_i, wb_sel_i);
        OFF_X2: x2_ff <= wr_merge(x2_ff, wb_dat_i, wb_sel_i);
        OFF_Y2: y2_ff <= wr_merge(y2_ff, wb_dat_i, wb_sel_i);
        OFF_NPTS: npts_ff <= 5'(wr_merge({27'h0, npts_ff}, wb_dat_i,
                                         wb_sel_i));
        OFF_MASK: mask_ff <= IRQ_W'(wr_merge({29'h0, mask_ff}, wb_dat_i,
                                             wb_sel_i));
        default: ;
      endcase
    end
  end

  // read mux; unmapped addresses read zero
  always_comb begin
    rd_val = 32'h0;
    case (wb_adr_i)
      OFF_CTRL: rd_val = ctrl_val;
      OFF_UPD: rd_val = {16'h0, upd_ff};
      OFF_TAU: rd_val = tau_ff;
      OFF_MIN: rd_val = min_ff;
      OFF_MAX: rd_val = max_ff;
      OFF_X1: rd_val = x1_ff;
      OFF_Y1: rd_val = y1_ff;
      OFF_X2: rd_val = x2_ff;
      OFF_Y2: rd_val = y2_ff;
      OFF_NPTS: rd_val = {27'h0, npts_ff};
      OFF_STAT: rd_val = {29'h0, st_ff != ST_IDLE, sig_ok_i, oor_o};
      OFF_IRQ: rd_val = {29'h0, irq_ff};
      OFF_MASK: rd_val = {29'h0, mask_ff};
      OFF_CIN: rd_val = curve_in_o;
      OFF_COUT: rd_val = curve_out_o;
      default: rd_val = 32'h0;
    endcase
  end

  // ack: one cycle for registers, two for table reads; a table read
  // waits while the curve walk owns the memory port
  always_ff @(posedge clk_i) begin
    wb_ack_o <= 1'b0;
    if (rst_i) begin
      wb_dat_o <= 32'h0;
      tbl_ph_ff <= 1'b0;
    end else if (tbl_ph_ff) begin
      tbl_ph_ff <= 1'b0;
      wb_ack_o <= 1'b1;
      wb_dat_o <= wb_adr_i[2] ? mem_q[63:32] : mem_q[31:0];
    end else if (rd_tbl) begin
      tbl_ph_ff <= (st_ff != ST_RD);
    end else if (req) begin
      wb_ack_o <= 1'b1;
      wb_dat_o <= wb_we_i ? 32'h0 : rd_val;
    end
  end

  msc_point_mem u_mem (
    .clk_i(clk_i),
    .wr_en_i(wr & tbl_ok),
    .wr_hi_i(wb_adr_i[2]),
    .wr_sel_i(wb_sel_i),
    .wr_idx_i(tidx[4:0]),
    .wr_data_i(wb_dat_i),
    .rd_idx_i((st_ff == ST_RD) ? idx_ff : tidx[4:0]),
    .rd_data_o(mem_q)
  );
  ////////////////////////////////////////////////////////////////////////
  // update tick: 5 ms prescaler, then a count of steps; zero acts as one
  always_ff @(posedge clk_i) begin
    if (rst_i || !en_ff) begin
      pre_ff <= 32'h0;
      step_ff <= 16'h0;
    end else if (pre_ff == 32'(STEP_CYCLES_P - 1)) begin
      pre_ff <= 32'h0;
      step_ff <= (step_ff + 16'h1 >= upd_ff) ? 16'h0 : step_ff + 16'h1;
    end else begin
      pre_ff <= pre_ff + 32'h1;
    end
  end
  assign tick = en_ff && (pre_ff == 32'(STEP_CYCLES_P - 1)) &&
                (step_ff + 16'h1 >= upd_ff);

  // measurement is taken only while the signal is good, so a lost signal
  // leaves the last valid value in place
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      meas_ff <= 32'h0;
      sig_d_ff <= 1'b0;
    end else begin
      sig_d_ff <= sig_ok_i;
      if (meas_stb_i && sig_ok_i) begin
        meas_ff <= meas_i;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // arithmetic feeding the shared divider
  assign dt_ms = 32'(upd_ff) * STEP_MS;
  assign fprod = 64'(signed'({meas_ff[31], meas_ff} - {filt_ff[31], filt_ff}))
                 * signed'({32'h0, dt_ms});
  assign px = mem_q[31:0];
  assign py = mem_q[63:32];
  assign x0 = (st_ff == ST_CMP) ? prevx_ff : x1_ff;
  assign y0 = (st_ff == ST_CMP) ? prevy_ff : y1_ff;
  assign xe = (st_ff == ST_CMP) ? px : x2_ff;
  assign ye = (st_ff == ST_CMP) ? py : y2_ff;
  assign iprod = 64'(signed'({curx_ff[31], curx_ff} - {x0[31], x0})) *
                 64'(signed'({ye[31], ye} - {y0[31], y0}));
  assign q32 = neg_ff ? 32'(-div_q) : div_q[31:0];
  assign rnd_up = (rnd_ff == RND_FLOOR) ? (neg_ff && div_r != 32'h0) :
                  (rnd_ff == RND_CEIL) ? (!neg_ff && div_r != 32'h0) :
                  (div_r >= HALF_SCALE);
  assign rnd_mag = 32'(div_q[31:0] * SCALE) + (rnd_up ? SCALE : 32'h0);

  msc_div u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .start_i(div_start_ff),
    .num_i(div_a_ff),
    .den_i(div_b_ff),
    .done_o(div_done),
    .quot_o(div_q),
    .rem_o(div_r)
  );

  // sequencer: filter, range check, curve walk, interpolate, round
  always_ff @(posedge clk_i) begin
    div_start_ff <= 1'b0;
    if (rst_i) begin
      st_ff <= ST_IDLE;
      {curx_ff, filt_ff, base_ff, res_ff, prevx_ff, prevy_ff} <= '0;
      {filt_init_ff, neg_ff, oor_new_ff} <= 3'h0;
      idx_ff <= 5'h0;
      div_a_ff <= 64'h0;
      div_b_ff <= 32'h0;
    end else begin
      case (st_ff)
        ST_IDLE: begin
          if (!en_ff || !filt_en_ff) begin
            filt_init_ff <= 1'b0;
          end
          if (tick) begin
            if (filt_en_ff && filt_init_ff) begin
              neg_ff <= fprod[63];
              div_a_ff <= mag64(fprod);
              div_b_ff <= tau_ff + dt_ms;
              div_start_ff <= 1'b1;
              st_ff <= ST_FILT;
            end else begin
              curx_ff <= meas_ff;
              filt_ff <= meas_ff;
              filt_init_ff <= filt_en_ff;
              st_ff <= ST_CHK;
            end
          end
        end
        ST_FILT: begin
          if (div_done) begin
            curx_ff <= filt_ff + q32;
            filt_ff <= filt_ff + q32;
            st_ff <= ST_CHK;
          end
        end
        ST_CHK: begin
          oor_new_ff <= oor_en_ff && (signed'(curx_ff) < signed'(min_ff) ||
                        signed'(curx_ff) > signed'(max_ff));
          idx_ff <= 5'h0;
          if (pts_en_ff) begin
            st_ff <= ST_RD;
          end else if (signed'(curx_ff) <= signed'(x1_ff)) begin
            res_ff <= y1_ff;
            st_ff <= ST_RES;
          end else if (signed'(curx_ff) >= signed'(x2_ff)) begin
            res_ff <= y2_ff;
            st_ff <= ST_RES;
          end else begin
            neg_ff <= iprod[63];
            base_ff <= y0;
            div_a_ff <= mag64(iprod);
            div_b_ff <= 32'(xe - x0);
            div_start_ff <= 1'b1;
            st_ff <= ST_DIV;
          end
        end
        ST_RD: st_ff <= ST_CMP;
        ST_CMP: begin
          if (signed'(curx_ff) <= signed'(px) && idx_ff == 5'h0) begin
            res_ff <= py;
            st_ff <= ST_RES;
          end else if (signed'(curx_ff) <= signed'(px)) begin
            neg_ff <= iprod[63];
            base_ff <= y0;
            div_a_ff <= mag64(iprod);
            div_b_ff <= 32'(xe - x0);
            div_start_ff <= 1'b1;
            st_ff <= ST_DIV;
          end else if (idx_ff + 5'h1 >= npts_ff || idx_ff + 5'h1 >= MAX_PTS)
          begin
            res_ff <= py;
            st_ff <= ST_RES;
          end else begin
            prevx_ff <= px;
            prevy_ff <= py;
            idx_ff <= idx_ff + 5'h1;
            st_ff <= ST_RD;
          end
        end
        ST_DIV: begin
          if (div_done) begin
            res_ff <= base_ff + q32;
            st_ff <= ST_RES;
          end
        end
        ST_RES: begin
          if (rnd_ff == RND_FLOAT) begin
            st_ff <= ST_DONE;
          end else begin
            neg_ff <= res_ff[31];
            div_a_ff <= mag64(64'(signed'(res_ff)));
            div_b_ff <= SCALE;
            div_start_ff <= 1'b1;
            st_ff <= ST_RND;
          end
        end
        ST_RND: begin
          if (div_done) begin
            res_ff <= neg_ff ? 32'(-rnd_mag) : rnd_mag;
            st_ff <= ST_DONE;
          end
        end
        ST_DONE: st_ff <= ST_IDLE;
        default: st_ff <= ST_IDLE;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  // results published together once per update cycle
  always_ff @(posedge clk_i) begin
    upd_o <= 1'b0;
    if (rst_i) begin
      oor_o <= 1'b0;
      curve_in_o <= 32'h0;
      curve_out_o <= 32'h0;
    end else if (!en_ff) begin
      oor_o <= 1'b0;
    end else if (st_ff == ST_DONE) begin
      oor_o <= oor_new_ff;
      curve_in_o <= curx_ff;
      curve_out_o <= res_ff;
      upd_o <= 1'b1;
    end
  end

  // sticky events, write one to clear; a new event beats the clear
  assign irq_set[IRQ_OOR] = en_ff && st_ff == ST_DONE && oor_new_ff && !oor_o;
  assign irq_set[IRQ_UPD] = en_ff && st_ff == ST_DONE;
  assign irq_set[IRQ_LOST] = sig_d_ff && !sig_ok_i;
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_ff <= '0;
      irq_o <= 1'b0;
    end else begin
      if (wr && wb_adr_i == OFF_IRQ) begin
        irq_ff <= (irq_ff & ~wmask[IRQ_W-1:0]) | irq_set;
      end else begin
        irq_ff <= irq_ff | irq_set;
      end
      irq_o <= |(irq_ff & mask_ff);
    end
  end
endmodule : msc_top
`default_nettype wire

// file: sim/msc_chk.sv
`timescale 1ns/100ps
`default_nettype none
module msc_chk #(
  parameter int STEP_CYCLES_P = 20
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic wb_ack_o,
  input wire logic sig_ok_i,
  input wire logic oor_o,
  input wire logic [31:0] curve_in_o,
  input wire logic [31:0] curve_out_o,
  input wire logic upd_o,
  input wire logic irq_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  ////////////////////////////////////////////////////////////////////////
  // curve input and output only move with the refresh pulse
  a_out_holds: assert property (!upd_o |-> $stable(curve_out_o))
    else $error("curve output moved without refresh");
  a_cin_holds: assert property (!upd_o |-> $stable(curve_in_o))
    else $error("curve input moved without refresh");
  a_upd_pulse: assert property (upd_o |=> !upd_o)
    else $error("refresh pulse longer than one cycle");
  // flag may drop at once on disable, but only rises with a refresh
  a_oor_on_upd: assert property ($rose(oor_o) |-> upd_o)
    else $error("range flag rose outside refresh");
  ////////////////////////////////////////////////////////////////////////
  // bus handshake, plus covers of range, write, signal loss and irq
  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  a_ack_req: assert property (wb_ack_o |-> $past(wb_cyc_i & wb_stb_i))
    else $error("ack without request");
  a_ack_bounded: assert property (
    wb_cyc_i && wb_stb_i && !wb_ack_o |-> ##[1:8] wb_ack_o)
    else $error("request not answered in time");
  a_ack_stays_low: assert property (!wb_cyc_i |=> !wb_ack_o)
    else $error("ack while bus idle");
  c_oor_upd: cover property (upd_o && oor_o);
  c_write: cover property (wb_ack_o && wb_we_i);
  c_lost: cover property ($fell(sig_ok_i));
  c_irq: cover property (irq_o);
endmodule : msc_chk
bind msc_top msc_chk #(.STEP_CYCLES_P(STEP_CYCLES_P)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
  .wb_we_i(wb_we_i), .wb_ack_o(wb_ack_o), .sig_ok_i(sig_ok_i), .oor_o(oor_o),
  .curve_in_o(curve_in_o), .curve_out_o(curve_out_o), .upd_o(upd_o),
  .irq_o(irq_o));
`default_nettype wire

// file: sim/msc_meas_src.sv
`timescale 1ns/100ps
`default_nettype none
module msc_meas_src (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [31:0] val_i,
  input wire logic ok_i,
  output logic [31:0] meas_o,
  output logic meas_stb_o,
  output logic sig_ok_o
);
  logic [3:0] cnt_ff;
  // strobes keep coming while lost and the data line toggles, so a
  // design that samples a dead input shows it at once
  always_ff @(posedge clk_i) begin
    cnt_ff <= rst_i ? 4'h0 : cnt_ff + 4'h1;
    meas_stb_o <= !rst_i && cnt_ff == 4'hF;
    meas_o <= rst_i ? 32'h0 : (ok_i ? val_i : ~meas_o);
    sig_ok_o <= ok_i;
  end
endmodule : msc_meas_src
`default_nettype wire

// file: sim/test_milliamp_input_scaling_curve.sv
`timescale 1ns/100ps
`default_nettype none
module test_milliamp_input_scaling_curve;
  import msc_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [8:0] adr = 9'h0;
  logic [3:0] sel = 4'hF;
  logic [31:0] dat = 32'h0;
  logic [31:0] val = 32'h0;
  logic ok = 1'b1;
  logic [31:0] dat_o, meas, cin, cout, q;
  logic ack, mstb, sok, oor, upd, irq;
  int n_errors = 0;
  int num_checks = 0;
  int n_upd = 0;
  logic [8:0] ra [12] = '{OFF_CTRL, OFF_UPD, OFF_TAU, OFF_MIN, OFF_MAX,
    OFF_X1, OFF_Y1, OFF_X2, OFF_Y2, OFF_NPTS, OFF_MASK, OFF_IRQ};
  logic [31:0] rv [12] = '{32'h0, 32'h1E, 32'h3E8, 32'h0, 32'h0, 32'h0,
    32'h0, 32'h186A0, 32'h0, 32'h2, 32'h0, 32'h0};
  logic [31:0] re [4] = '{32'h3D090, 32'h30D40, 32'h493E0, 32'h493E0};
  logic [31:0] px [3] = '{32'h0, 32'hC350, 32'h186A0};
  logic [31:0] py [3] = '{32'h0, 32'h186A0, 32'h493E0};
  always #25 clk_i = ~clk_i;
  // step shortened to 20 clocks so an update cycle stays short
  msc_top #(.STEP_CYCLES_P(20)) DUT (.clk_i(clk_i), .rst_i(rst_i),
    .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(dat_o), .wb_ack_o(ack),
    .meas_i(meas), .meas_stb_i(mstb), .sig_ok_i(sok), .oor_o(oor),
    .curve_in_o(cin), .curve_out_o(cout), .upd_o(upd), .irq_o(irq));
  msc_meas_src u_src (.clk_i(clk_i), .rst_i(rst_i), .val_i(val), .ok_i(ok),
    .meas_o(meas), .meas_stb_o(mstb), .sig_ok_o(sok));
  // count refresh pulses for the disabled check
  always @(posedge clk_i) begin
    if (upd === 1'b1) n_upd++;
  end
  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  // classic cycle; ack and data are taken at the rising edge that sees ack
  // high and the request is released at that edge; a hang is left to the
  // watchdog, so no wait count lives here
  task automatic wb(input logic w, input logic [8:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dat <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = dat_o;
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask : wb
  task automatic wr(input logic [8:0] a, input logic [31:0] d);
    wb(1'b1, a, d);
  endtask : wr
  task automatic rc(input logic [8:0] a, input logic [31:0] e);
    wb(1'b0, a, 32'h0);
    chk(q, e);
  endtask : rc
  // the second refresh is the first one surely built from new settings
  task automatic wu(input int k);
    int n;
    n = 0;
    while (k > 0 && n < 4000) begin
      @(negedge clk_i);
      n++;
      if (upd === 1'b1) k--;
    end
    if (n >= 4000) begin
      n_errors++;
      report_and_stop();
    end
  endtask : wu
  task automatic sc(input logic [31:0] x, input logic [31:0] ei,
                    input logic [31:0] eo);
    @(posedge clk_i);
    val <= x;
    wu(2);
    chk(cin, ei);
    chk(cout, eo);
  endtask : sc
  task automatic report_and_stop;
    $display("checks=%0d errors=%0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : report_and_stop
  ////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (60000) @(posedge clk_i);
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int i = 0; i < 12; i++) rc(ra[i], rv[i]);
    wr(9'h03C, 32'hFFFFFFFF);
    rc(9'h03C, 32'h0);
    wr(OFF_COUT, 32'h12345678);
    rc(OFF_COUT, 32'h0);
    repeat (1000) @(posedge clk_i);
    chk(n_upd, 0);
    wr(OFF_UPD, 32'h14);
    wr(OFF_Y2, 32'hF4240);
    wr(OFF_MIN, 32'h2710);
    wr(OFF_MAX, 32'h15F90);
    wr(OFF_CTRL, 32'h1);
    sc(32'h61A8, 32'h61A8, 32'h3D090);
    rc(OFF_CIN, 32'h61A8);
    rc(OFF_COUT, 32'h3D090);
    sc(32'h1D4C0, 32'h1D4C0, 32'hF4240);
    chk(oor, 1'b0);
    for (int m = 0; m < 4; m++) begin
      wr(OFF_CTRL, 32'(1 + m * 16));
      sc(32'h61A8, 32'h61A8, re[m]);
    end
    wr(OFF_CTRL, 32'h5);
    sc(32'h61A8, 32'h61A8, 32'h3D090);
    chk(oor, 1'b0);
    sc(32'h1D4C0, 32'h1D4C0, 32'hF4240);
    chk(oor, 1'b1);
    rc(OFF_IRQ, 32'h3);
    chk(irq, 1'b0);
    wr(OFF_MASK, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b1);
    wr(OFF_IRQ, 32'h1);
    repeat (2) @(posedge clk_i);
    chk(irq, 1'b0);
    sc(32'h1388, 32'h1388, 32'hC350);
    chk(oor, 1'b1);
    wr(OFF_CTRL, 32'h1);
    // the flag is only recomputed with a refresh, so wait for a clean one
    wu(2);
    chk(oor, 1'b0);
    sc(32'hEA60, 32'hEA60, 32'h927C0);
    @(posedge clk_i);
    ok <= 1'b0;
    wu(2);
    chk(cin, 32'hEA60);
    chk(cout, 32'h927C0);
    rc(OFF_IRQ, 32'h6);
    ok <= 1'b1;
    for (int i = 0; i < 3; i++) begin
      wr(9'(9'h080 + i * 8), px[i]);
      wr(9'(9'h084 + i * 8), py[i]);
    end
    wr(OFF_NPTS, 32'h3);
    wr(OFF_CTRL, 32'h9);
    sc(32'h124F8, 32'h124F8, 32'h30D40);
    rc(9'h088, 32'hC350);
    sc(32'h0, 32'h0, 32'h0);
    wr(OFF_TAU, 32'h64);
    wr(OFF_CTRL, 32'h3);
    wu(2);
    @(posedge clk_i);
    val <= 32'h13880;
    wu(2);
    chk(32'(cin === 32'h9C40 || cin === 32'hEA60), 32'h1);
    report_and_stop();
  end
endmodule : test_milliamp_input_scaling_curve
`default_nettype wire
